// ---- logic/t8c_defs.svh ----
`ifndef T8C_DEFS_SVH
`define T8C_DEFS_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define T8C_IDX_FLAGS   8'h15
`define T8C_IDX_CTLA    8'h24
`define T8C_IDX_CTLB    8'h25
`define T8C_IDX_COUNT   8'h26
`define T8C_IDX_CMPA    8'h27
`define T8C_IDX_CMPB    8'h28
`define T8C_IDX_MASK    8'h2E
`define T8C_IDX_GLOBAL  8'h2F

// ----------------------------------------
// Field positions
// ----------------------------------------
`define T8C_BIT_FORCE_A 7
`define T8C_BIT_FORCE_B 6
`define T8C_BIT_WGM2    3
`define T8C_CS_MSB      2
`define T8C_CS_LSB      0
`define T8C_COMA_MSB    7
`define T8C_COMA_LSB    6
`define T8C_COMB_MSB    5
`define T8C_COMB_LSB    4
`define T8C_WGML_MSB    1
`define T8C_WGML_LSB    0
`define T8C_BIT_CMP_B   2
`define T8C_BIT_CMP_A   1
`define T8C_BIT_OVF     0
`define T8C_BIT_GIE     0

// ----------------------------------------
// Reset values and counter limits
// ----------------------------------------
`define T8C_RST_REG     8'h00
`define T8C_MAX         8'hFF
`define T8C_BOTTOM      8'h00

// ----------------------------------------
// Prescaler divisors and bus answers
// ----------------------------------------
`define T8C_DIV_8       8
`define T8C_DIV_64      64
`define T8C_DIV_256     256
`define T8C_DIV_1024    1024
`define T8C_RESP_OKAY   2'b00
`define T8C_RESP_SLVERR 2'b10

`endif

// ---- logic/t8c_pkg.sv ----
package t8c_pkg;

	// Waveform mode, codes 0..7 in declaration order
	typedef enum logic [2:0] {
		WM_NORMAL,
		WM_PC_MAX,
		WM_CTC,
		WM_FAST_MAX,
		WM_RSVD4,
		WM_PC_CMPA,
		WM_RSVD6,
		WM_FAST_CMPA
	} t8c_wmode_t;

endpackage

// ---- logic/t8c_clk_sel.sv ----
`timescale 1ns/1ns
`include "t8c_defs.svh"

module t8c_clk_sel #(
	parameter int PRESC_W = 10
) (
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic [2:0] clkSel,
	input  wire logic       countPin,
	output logic            tick
);

	if (PRESC_W < 10) begin : g_bad_width
		$error("PRESC_W too small for the largest divisor");
	end

	logic [PRESC_W-1:0] presc_r;
	logic               pinPrev_r;

	// Due once per divisor period: low bits all ones
	function automatic logic isDue(logic [PRESC_W-1:0] p, int div);
		logic [PRESC_W-1:0] m;
		m = PRESC_W'(div - 1);
		return (p & m) == m;
	endfunction

	// Free running, never reset by selection changes
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			presc_r <= '0;
		end else begin
			presc_r <= presc_r + PRESC_W'(1);
		end
	end

	// Previous pin sample for edge detection
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pinPrev_r <= 1'b0;
		end else begin
			pinPrev_r <= countPin;
		end
	end

	// Pin edges count even when the pin is driven locally
	always_comb begin
		unique case (clkSel)
			3'h0: tick = 1'b0;
			3'h1: tick = 1'b1;
			3'h2: tick = isDue(presc_r, `T8C_DIV_8);
			3'h3: tick = isDue(presc_r, `T8C_DIV_64);
			3'h4: tick = isDue(presc_r, `T8C_DIV_256);
			3'h5: tick = isDue(presc_r, `T8C_DIV_1024);
			3'h6: tick = pinPrev_r & ~countPin;
			3'h7: tick = ~pinPrev_r & countPin;
		endcase
	end

	a_presc_by8:
	assert property (@(posedge ref_clk) disable iff (!rstn)
		(tick && clkSel == 3'h2) |=> (!tick || clkSel != 3'h2)[*7])
	else $error("divide-by-8 tick came early");

	a_ext_rising:
	assert property (@(posedge ref_clk) disable iff (!rstn)
		(clkSel == 3'h7 && countPin && !$past(countPin)) |-> tick)
	else $error("rising pin edge gave no tick");

endmodule

// ---- logic/t8c_timer.sv ----
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ns
`include "t8c_defs.svh"

module t8c_timer #(
	parameter int ADDR_W  = 12,
	parameter int PRESC_W = 10
) (
	input  wire logic              ref_clk,
	input  wire logic              rstn,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic              countPin,
	input  wire logic              vecAckA,
	input  wire logic              vecAckB,
	input  wire logic              vecAckOvf,
	output logic                   irqMatchA,
	output logic                   irqMatchB,
	output logic                   irqOverflow,
	output logic                   waveOutA,
	output logic                   waveOutB,
	output logic                   waveEnA,
	output logic                   waveEnB
);

	if (ADDR_W < 10) begin : g_bad_addr
		$error("ADDR_W too small for the register map");
	end

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [1:0]  comA_r, comB_r, wgmLow_r;
	logic        wgm2_r, gie_r, down_r, blockNext_r;
	logic [2:0]  clkSel_r, mask_r, flags_r, flags_nxt;
	logic [7:0]  cnt_r, cnt_nxt, cmpA_r, cmpB_r, rdMux, top;
	logic        down_nxt, tick;
	logic        awHeld_r, wHeld_r, wStrb0_r;
	logic [7:0]  awIdx_r, wData_r, arIdx;
	logic        wrFire, wrEn, wrCtlA, wrCtlB, wrCnt;
	logic        forceA, forceB, hitA, hitB, ovfEv, botEv;
	t8c_pkg::t8c_wmode_t mode;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] regIdx(logic [ADDR_W-1:0] a);
		return a[9:2];
	endfunction

	function automatic logic isMapped(logic [7:0] i);
		return i == `T8C_IDX_FLAGS || i == `T8C_IDX_CTLA ||
			i == `T8C_IDX_CTLB || i == `T8C_IDX_COUNT ||
			i == `T8C_IDX_CMPA || i == `T8C_IDX_CMPB ||
			i == `T8C_IDX_MASK || i == `T8C_IDX_GLOBAL;
	endfunction

	function automatic logic isPc(t8c_pkg::t8c_wmode_t m);
		return m == t8c_pkg::WM_PC_MAX || m == t8c_pkg::WM_PC_CMPA;
	endfunction

	function automatic logic isPwm(t8c_pkg::t8c_wmode_t m);
		return isPc(m) || m == t8c_pkg::WM_FAST_MAX ||
			m == t8c_pkg::WM_FAST_CMPA;
	endfunction

	function automatic logic topIsA(t8c_pkg::t8c_wmode_t m);
		return m == t8c_pkg::WM_CTC || m == t8c_pkg::WM_PC_CMPA ||
			m == t8c_pkg::WM_FAST_CMPA;
	endfunction

	// Next pin level; output mode is sampled at the event
	function automatic logic waveNext(logic cur, logic [1:0] com,
		t8c_pkg::t8c_wmode_t m, logic isA, logic hit, logic bot,
		logic dn);
		logic r;
		r = cur;
		if (!isPwm(m)) begin
			if (hit && com == 2'b01) r = ~cur;
			if (hit && com[1]) r = com[0];
		end else if (com == 2'b01) begin
			if (hit && isA && m[2]) r = ~cur;
		end else if (com[1]) begin
			if (hit) r = com[0] ^ dn;
			// Bottom wins when compare equals top
			if (bot) r = ~com[0];
		end
		return r;
	endfunction

	// ----------------------------------------
	// Mode decode and clock selection
	// ----------------------------------------
	assign mode = t8c_pkg::t8c_wmode_t'({wgm2_r, wgmLow_r});
	assign top  = topIsA(mode) ? cmpA_r : `T8C_MAX;

	t8c_clk_sel #(
		.PRESC_W (PRESC_W)
	) u_clk_sel (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.clkSel   (clkSel_r),
		.countPin (countPin),
		.tick     (tick)
	);

	// ----------------------------------------
	// Bus slave: one write, one read at a time
	// ----------------------------------------
	assign awready = !awHeld_r;
	assign wready  = !wHeld_r;
	assign arready = !rvalid;
	assign wrFire  = awHeld_r && wHeld_r && !bvalid;
	assign wrEn    = wrFire && wStrb0_r; // upper lanes hold nothing
	assign wrCtlA  = wrEn && awIdx_r == `T8C_IDX_CTLA;
	assign wrCtlB  = wrEn && awIdx_r == `T8C_IDX_CTLB;
	assign wrCnt   = wrEn && awIdx_r == `T8C_IDX_COUNT;
	assign arIdx   = regIdx(araddr);

	// Address and data may arrive in either order
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			awHeld_r <= 1'b0;
			awIdx_r  <= `T8C_RST_REG;
		end else if (awvalid && awready) begin
			awHeld_r <= 1'b1;
			awIdx_r  <= regIdx(awaddr);
		end else if (wrFire) begin
			awHeld_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wHeld_r  <= 1'b0;
			wData_r  <= `T8C_RST_REG;
			wStrb0_r <= 1'b0;
		end else if (wvalid && wready) begin
			wHeld_r  <= 1'b1;
			wData_r  <= wdata[7:0];
			wStrb0_r <= wstrb[0];
		end else if (wrFire) begin
			wHeld_r <= 1'b0;
		end
	end

	// Unmapped index answers SLVERR and writes nothing
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			bvalid <= 1'b0;
			bresp  <= `T8C_RESP_OKAY;
		end else if (wrFire) begin
			bvalid <= 1'b1;
			bresp  <= isMapped(awIdx_r) ? `T8C_RESP_OKAY :
				`T8C_RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// Read data mux; force and reserved bits read zero
	always_comb begin
		rdMux = `T8C_RST_REG;
		unique case (arIdx)
			`T8C_IDX_CTLA:   rdMux = {comA_r, comB_r, 2'h0, wgmLow_r};
			`T8C_IDX_CTLB:   rdMux = {4'h0, wgm2_r, clkSel_r};
			`T8C_IDX_COUNT:  rdMux = cnt_r;
			`T8C_IDX_CMPA:   rdMux = cmpA_r;
			`T8C_IDX_CMPB:   rdMux = cmpB_r;
			`T8C_IDX_MASK:   rdMux = {5'h00, mask_r};
			`T8C_IDX_FLAGS:  rdMux = {5'h00, flags_r};
			`T8C_IDX_GLOBAL: rdMux = {7'h00, gie_r};
			default:         rdMux = `T8C_RST_REG;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= `T8C_RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata  <= {24'h00_0000, rdMux};
			rresp  <= isMapped(arIdx) ? `T8C_RESP_OKAY :
				`T8C_RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			comA_r   <= 2'h0;
			comB_r   <= 2'h0;
			wgmLow_r <= 2'h0;
			wgm2_r   <= 1'b0;
			clkSel_r <= 3'h0;
		end else begin
			if (wrCtlA) begin
				comA_r   <= wData_r[`T8C_COMA_MSB:`T8C_COMA_LSB];
				comB_r   <= wData_r[`T8C_COMB_MSB:`T8C_COMB_LSB];
				wgmLow_r <= wData_r[`T8C_WGML_MSB:`T8C_WGML_LSB];
			end
			if (wrCtlB) begin
				wgm2_r   <= wData_r[`T8C_BIT_WGM2];
				clkSel_r <= wData_r[`T8C_CS_MSB:`T8C_CS_LSB];
			end
		end
	end

	// Compare values, mask and global enable
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cmpA_r <= `T8C_RST_REG;
			cmpB_r <= `T8C_RST_REG;
			mask_r <= 3'h0;
			gie_r  <= 1'b0;
		end else if (wrEn) begin
			if (awIdx_r == `T8C_IDX_CMPA) cmpA_r <= wData_r;
			if (awIdx_r == `T8C_IDX_CMPB) cmpB_r <= wData_r;
			if (awIdx_r == `T8C_IDX_MASK) mask_r <= wData_r[2:0];
			if (awIdx_r == `T8C_IDX_GLOBAL) gie_r <= wData_r[`T8C_BIT_GIE];
		end
	end

	// Strobes live one cycle only; PWM modes drop them
	assign forceA = wrCtlB && wData_r[`T8C_BIT_FORCE_A] && !isPwm(mode);
	assign forceB = wrCtlB && wData_r[`T8C_BIT_FORCE_B] && !isPwm(mode);

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	always_comb begin
		cnt_nxt  = cnt_r;
		down_nxt = down_r;
		if (isPc(mode)) begin
			if (!down_r) begin
				if (cnt_r >= top) begin
					down_nxt = 1'b1;
					cnt_nxt  = cnt_r - 8'h01;
				end else begin
					cnt_nxt = cnt_r + 8'h01;
				end
			end else if (cnt_r == `T8C_BOTTOM) begin
				down_nxt = 1'b0;
				cnt_nxt  = cnt_r + 8'h01;
			end else begin
				cnt_nxt = cnt_r - 8'h01;
			end
		end else begin
			down_nxt = 1'b0;
			// Only a real match clears; a forced one never does
			if (topIsA(mode) && cnt_r == top) begin
				cnt_nxt = `T8C_BOTTOM;
			end else begin
				cnt_nxt = cnt_r + 8'h01;
			end
		end
	end

	// Software write beats a tick in the same cycle
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_r  <= `T8C_RST_REG;
			down_r <= 1'b0;
		end else if (wrCnt) begin
			cnt_r <= wData_r;
		end else if (tick) begin
			cnt_r  <= cnt_nxt;
			down_r <= down_nxt;
		end
	end

	// Held until the first tick after a counter write
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			blockNext_r <= 1'b0;
		end else if (wrCnt) begin
			blockNext_r <= 1'b1;
		end else if (tick) begin
			blockNext_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Compare, overflow and waveform events
	// ----------------------------------------
	assign hitA  = tick && !blockNext_r && cnt_r == cmpA_r;
	assign hitB  = tick && !blockNext_r && cnt_r == cmpB_r;
	assign botEv = tick && cnt_r == top &&
		(mode == t8c_pkg::WM_FAST_MAX || mode == t8c_pkg::WM_FAST_CMPA);
	assign ovfEv = tick && (isPc(mode) ? (down_r && cnt_r == `T8C_BOTTOM) :
		mode == t8c_pkg::WM_FAST_CMPA ? cnt_r == top :
		cnt_r == `T8C_MAX);

	// Pins keep their level while disconnected
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			waveOutA <= 1'b0;
			waveOutB <= 1'b0;
		end else begin
			waveOutA <= waveNext(waveOutA, comA_r, mode, 1'b1,
				hitA || forceA, botEv, down_r);
			waveOutB <= waveNext(waveOutB, comB_r, mode, 1'b0,
				hitB || forceB, botEv, down_r);
		end
	end

	assign waveEnA = comA_r != 2'h0;
	assign waveEnB = comB_r != 2'h0;

	// ----------------------------------------
	// Flags and requests
	// ----------------------------------------
	// Set wins over both software and vector clears
	always_comb begin
		flags_nxt = flags_r;
		if (wrEn && awIdx_r == `T8C_IDX_FLAGS) begin
			flags_nxt = flags_nxt & ~wData_r[2:0];
		end
		flags_nxt = flags_nxt & ~{vecAckB, vecAckA, vecAckOvf};
		flags_nxt[`T8C_BIT_CMP_B] = flags_nxt[`T8C_BIT_CMP_B] | hitB;
		flags_nxt[`T8C_BIT_CMP_A] = flags_nxt[`T8C_BIT_CMP_A] | hitA;
		flags_nxt[`T8C_BIT_OVF]   = flags_nxt[`T8C_BIT_OVF] | ovfEv;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			flags_r <= 3'h0;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	assign irqMatchA   = gie_r && mask_r[`T8C_BIT_CMP_A] &&
		flags_r[`T8C_BIT_CMP_A];
	assign irqMatchB   = gie_r && mask_r[`T8C_BIT_CMP_B] &&
		flags_r[`T8C_BIT_CMP_B];
	assign irqOverflow = gie_r && mask_r[`T8C_BIT_OVF] &&
		flags_r[`T8C_BIT_OVF];

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_ctlb_read_zero:
	assert property (@(posedge ref_clk) disable iff (!rstn)
		(arvalid && arready && arIdx == `T8C_IDX_CTLB) |=>
		(rvalid && rdata[31:4] == 28'h000_0000))
	else $error("control_b read shows force or reserved bits");

	a_force_no_flag:
	assert property (@(posedge ref_clk) disable iff (!rstn)
		(forceA && !hitA && !vecAckA) |=>
		flags_r[`T8C_BIT_CMP_A] == $past(flags_r[`T8C_BIT_CMP_A]))
	else $error("forced compare changed the match flag");

	a_force_pwm_drop:
	assert property (@(posedge ref_clk) disable iff (!rstn)
		(wrCtlB && wData_r[`T8C_BIT_FORCE_A] && isPwm(mode) && !tick)
		|=> $stable(waveOutA))
	else $error("force strobe acted in a PWM mode");

	a_force_toggle:
	assert property (@(posedge ref_clk) disable iff (!rstn)
		(forceA && comA_r == 2'b01 && !hitA) |=> waveOutA != $past(waveOutA))
	else $error("forced compare did not toggle the pin");

	a_flag_w1c:
	assert property (@(posedge ref_clk) disable iff (!rstn)
		(wrEn && awIdx_r == `T8C_IDX_FLAGS && wData_r[`T8C_BIT_CMP_A]
		&& !hitA) |=> !flags_r[`T8C_BIT_CMP_A])
	else $error("write of one left the flag set");

	a_match_sets_b:
	assert property (@(posedge ref_clk) disable iff (!rstn)
		(tick && !blockNext_r && cnt_r == cmpB_r) |=> flags_r[`T8C_BIT_CMP_B])
	else $error("match B did not set its flag");

	a_cnt_write_block:
	assert property (@(posedge ref_clk) disable iff (!rstn)
		wrCnt ##1 (tick && !wrCnt) |-> (!hitA && !hitB))
	else $error("match after counter write not blocked");

	a_stopped_hold:
	assert property (@(posedge ref_clk) disable iff (!rstn)
		(clkSel_r == 3'h0 && !wrCnt) [*2] |-> $stable(cnt_r))
	else $error("counter moved with no clock selected");

	a_ovf_at_max:
	assert property (@(posedge ref_clk) disable iff (!rstn)
		(mode == t8c_pkg::WM_NORMAL && tick && cnt_r == `T8C_MAX)
		|=> (flags_r[`T8C_BIT_OVF] && cnt_r == `T8C_BOTTOM || $past(wrCnt)))
	else $error("overflow at max not flagged");

	a_irq_gate:
	assert property (@(posedge ref_clk) disable iff (!rstn)
		$rose(flags_r[`T8C_BIT_OVF]) && gie_r && mask_r[`T8C_BIT_OVF]
		|-> irqOverflow)
	else $error("enabled overflow raised no request");

endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
`include "t8c_defs.svh"

`define CHK(g, e) begin \
	samplesChecked++; \
	if ((g) !== (e)) begin \
		errTotal++; \
		$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); \
	end \
end

module tb_top;
	logic        ref_clk;
	logic        rstn;
	logic [11:0] awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [11:0] araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic        countPin;
	logic        vecAckA;
	logic        vecAckB;
	logic        vecAckOvf;
	logic        irqMatchA;
	logic        irqMatchB;
	logic        irqOverflow;
	logic        waveOutA;
	logic        waveOutB;
	logic        waveEnA;
	logic        waveEnB;
	logic [31:0] rdVal;
	logic [1:0]  rdResp;
	logic [1:0]  wrResp;
	logic        w0;
	int          errTotal;
	int          samplesChecked;

	t8c_timer dut_u (
		.ref_clk(ref_clk), .rstn(rstn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .countPin(countPin), .vecAckA(vecAckA),
		.vecAckB(vecAckB), .vecAckOvf(vecAckOvf),
		.irqMatchA(irqMatchA), .irqMatchB(irqMatchB),
		.irqOverflow(irqOverflow), .waveOutA(waveOutA),
		.waveOutB(waveOutB), .waveEnA(waveEnA), .waveEnB(waveEnB)
	);

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	// Handshakes sampled at the falling edge, where nothing moves
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic a, w, b, done;
		int   n;
		done = 1'b0;
		@(posedge ref_clk);
		awaddr <= {2'b00, idx, 2'b00};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40 && !done; n++) begin
			@(negedge ref_clk);
			a = awvalid & awready;
			w = wvalid & wready;
			b = bvalid & bready;
			wrResp = bresp;
			@(posedge ref_clk);
			if (a) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
			if (b) bready <= 1'b0;
			done = b;
		end
		if (!done) errTotal++;
	endtask

	task automatic rd(input logic [7:0] idx);
		logic a, r, done;
		int   n;
		done = 1'b0;
		@(posedge ref_clk);
		araddr <= {2'b00, idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40 && !done; n++) begin
			@(negedge ref_clk);
			a = arvalid & arready;
			r = rvalid & rready;
			rdVal = rdata;
			rdResp = rresp;
			@(posedge ref_clk);
			if (a) arvalid <= 1'b0;
			if (r) rready <= 1'b0;
			done = r;
		end
		if (!done) errTotal++;
	endtask

	task automatic expRd(input logic [7:0] idx, input logic [7:0] e);
		rd(idx);
		`CHK(rdVal, {24'h0, e})
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Reset values, reserved bits, counter access
	task automatic testRegs();
		expRd(`T8C_IDX_CTLB, 8'h00);
		expRd(`T8C_IDX_MASK, 8'h00);
		wr(`T8C_IDX_CTLB, 8'h38);
		expRd(`T8C_IDX_CTLB, 8'h08);
		wr(`T8C_IDX_CTLB, 8'h00);
		wr(`T8C_IDX_MASK, 8'hFF);
		expRd(`T8C_IDX_MASK, 8'h07);
		wr(`T8C_IDX_COUNT, 8'hA5);
		expRd(`T8C_IDX_COUNT, 8'hA5);
		$display("test regs done");
	endtask

	// Every internal divisor; window covers a few ticks
	task automatic testPresc();
		int divs[5] = '{1, 8, 64, 256, 1024};
		int i, win, lo, hi;
		for (i = 0; i < 5; i++) begin
			win = (divs[i] == 1) ? 20 : 4 * divs[i];
			lo = win / divs[i];
			hi = lo + ((divs[i] == 1) ? 8 : 1);
			wr(`T8C_IDX_COUNT, 8'h00);
			wr(`T8C_IDX_CTLB, 8'(i + 1));
			repeat (win) @(posedge ref_clk);
			wr(`T8C_IDX_CTLB, 8'h00);
			rd(`T8C_IDX_COUNT);
			`CHK(rdVal >= lo && rdVal <= hi, 1'b1)
			expRd(`T8C_IDX_COUNT, rdVal[7:0]);
		end
		$display("test prescaler done");
	endtask

	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			countPin <= 1'b1;
			repeat (3) @(posedge ref_clk);
			countPin <= 1'b0;
			repeat (3) @(posedge ref_clk);
		end
	endtask

	// Rising edges, then falling edges, of the count pin
	task automatic testPin();
		wr(`T8C_IDX_COUNT, 8'h00);
		wr(`T8C_IDX_CTLB, 8'h07);
		pulses(3);
		expRd(`T8C_IDX_COUNT, 8'h03);
		wr(`T8C_IDX_CTLB, 8'h06);
		pulses(2);
		expRd(`T8C_IDX_COUNT, 8'h05);
		wr(`T8C_IDX_CTLB, 8'h00);
		$display("test pin done");
	endtask

	// Matches set flags; request gating; both ways of clearing
	task automatic testFlags();
		wr(`T8C_IDX_CMPA, 8'h05);
		wr(`T8C_IDX_CMPB, 8'h09);
		wr(`T8C_IDX_COUNT, 8'h00);
		wr(`T8C_IDX_FLAGS, 8'h07);
		wr(`T8C_IDX_CTLB, 8'h01);
		repeat (20) @(posedge ref_clk);
		wr(`T8C_IDX_CTLB, 8'h00);
		expRd(`T8C_IDX_FLAGS, 8'h06);
		wr(`T8C_IDX_MASK, 8'h07);
		`CHK(irqMatchA | irqMatchB, 1'b0)
		wr(`T8C_IDX_GLOBAL, 8'h01);
		`CHK({irqMatchB, irqMatchA, irqOverflow}, 3'b110)
		wr(`T8C_IDX_MASK, 8'h02);
		`CHK({irqMatchB, irqMatchA}, 2'b01)
		wr(`T8C_IDX_MASK, 8'h07);
		wr(`T8C_IDX_FLAGS, 8'h00);
		expRd(`T8C_IDX_FLAGS, 8'h06);
		wr(`T8C_IDX_FLAGS, 8'h02);
		expRd(`T8C_IDX_FLAGS, 8'h04);
		`CHK({irqMatchB, irqMatchA}, 2'b10)
		@(posedge ref_clk);
		vecAckB <= 1'b1;
		@(posedge ref_clk);
		vecAckB <= 1'b0;
		expRd(`T8C_IDX_FLAGS, 8'h00);
		wr(`T8C_IDX_GLOBAL, 8'h00);
		$display("test flags done");
	endtask

	// Overflow at max in normal mode, at top in fast PWM to A
	task automatic testOvf();
		wr(`T8C_IDX_CMPA, 8'h80);
		wr(`T8C_IDX_CMPB, 8'h80);
		wr(`T8C_IDX_COUNT, 8'hF0);
		wr(`T8C_IDX_CTLB, 8'h01);
		repeat (20) @(posedge ref_clk);
		wr(`T8C_IDX_CTLB, 8'h00);
		expRd(`T8C_IDX_FLAGS, 8'h01);
		@(posedge ref_clk);
		vecAckOvf <= 1'b1;
		@(posedge ref_clk);
		vecAckOvf <= 1'b0;
		expRd(`T8C_IDX_FLAGS, 8'h00);
		wr(`T8C_IDX_CMPA, 8'h10);
		wr(`T8C_IDX_COUNT, 8'h00);
		wr(`T8C_IDX_CTLA, 8'h03);
		wr(`T8C_IDX_CTLB, 8'h09);
		repeat (40) @(posedge ref_clk);
		wr(`T8C_IDX_CTLB, 8'h00);
		rd(`T8C_IDX_FLAGS);
		`CHK(rdVal[0], 1'b1)
		rd(`T8C_IDX_COUNT);
		`CHK(rdVal <= 32'h10, 1'b1)
		wr(`T8C_IDX_FLAGS, 8'h07);
		$display("test overflow done");
	endtask

	// Phase correct to 255: no overflow at max, overflow at bottom
	task automatic testPc();
		wr(`T8C_IDX_COUNT, 8'hF0);
		wr(`T8C_IDX_CTLA, 8'h01);
		wr(`T8C_IDX_CTLB, 8'h01);
		repeat (20) @(posedge ref_clk);
		rd(`T8C_IDX_FLAGS);
		`CHK(rdVal[0], 1'b0)
		// Counter written while counting down keeps its direction
		wr(`T8C_IDX_COUNT, 8'h05);
		repeat (20) @(posedge ref_clk);
		wr(`T8C_IDX_CTLB, 8'h00);
		rd(`T8C_IDX_FLAGS);
		`CHK(rdVal[0], 1'b1)
		wr(`T8C_IDX_CTLA, 8'h00);
		wr(`T8C_IDX_FLAGS, 8'h07);
		$display("test phase correct done");
	endtask

	// Forced matches in clear-on-match mode, then ignored in PWM
	task automatic testForce();
		wr(`T8C_IDX_COUNT, 8'h33);
		wr(`T8C_IDX_CMPA, 8'h80);
		wr(`T8C_IDX_CTLA, 8'h72);
		@(negedge ref_clk);
		`CHK({waveEnA, waveEnB}, 2'b11)
		w0 = waveOutA;
		wr(`T8C_IDX_CTLB, 8'hC0);
		@(negedge ref_clk);
		`CHK({waveOutA, waveOutB}, {~w0, 1'b1})
		expRd(`T8C_IDX_CTLB, 8'h00);
		expRd(`T8C_IDX_FLAGS, 8'h00);
		expRd(`T8C_IDX_COUNT, 8'h33);
		wr(`T8C_IDX_CTLA, 8'h43);
		@(negedge ref_clk);
		w0 = waveOutA;
		// Breaks the software rule on purpose to show the strobe is dead
		wr(`T8C_IDX_CTLB, 8'h80);
		@(negedge ref_clk);
		`CHK(waveOutA, w0)
		wr(`T8C_IDX_CTLA, 8'h00);
		$display("test force done");
	endtask

	// Running counter written onto the compare value: next tick is blind
	task automatic testBlock();
		wr(`T8C_IDX_CMPA, 8'h40);
		wr(`T8C_IDX_FLAGS, 8'h07);
		wr(`T8C_IDX_CTLB, 8'h01);
		wr(`T8C_IDX_COUNT, 8'h40);
		repeat (4) @(posedge ref_clk);
		wr(`T8C_IDX_CTLB, 8'h00);
		expRd(`T8C_IDX_FLAGS, 8'h00);
		$display("test block done");
	endtask

	task automatic testUnmapped();
		wr(8'h01, 8'hFF);
		`CHK(wrResp, `T8C_RESP_SLVERR)
		rd(8'h01);
		`CHK({rdResp, rdVal}, {`T8C_RESP_SLVERR, 32'h0})
		$display("test unmapped done");
	endtask

	// ----------------------------------------
	// Clock, reset, sequence
	// ----------------------------------------
	task automatic finishTest();
		$display("checks %0d mismatches %0d", samplesChecked, errTotal);
		if (errTotal == 0 && samplesChecked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// Whole run needs well under 12000 cycles
	initial begin
		repeat (30000) @(posedge ref_clk);
		errTotal++;
		finishTest();
	end

	initial begin
		errTotal = 0;
		samplesChecked = 0;
		rstn = 1'b0;
		{awaddr, awvalid, wdata, wvalid, bready} = '0;
		{araddr, arvalid, rready, countPin} = '0;
		{vecAckA, vecAckB, vecAckOvf} = '0;
		wstrb = 4'hF;
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		testRegs();
		testPresc();
		testPin();
		testFlags();
		testOvf();
		testPc();
		testForce();
		testBlock();
		testUnmapped();
		finishTest();
	end
endmodule
